/* logic/reset_test_timer_pin_mux.sv */
// Pin multiplexer for reset, timer, clock out and test port pins
`timescale 1ns/1ps
`default_nettype none

module reset_test_timer_pin_mux (
   // Clock and power-on reset
   input wire logic ref_clk,
   input wire logic rst,
   // Avalon-MM register slave
   input wire logic [pin_mux_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [pin_mux_pkg::DATA_W-1:0] avs_writedata,
   output var logic [pin_mux_pkg::DATA_W-1:0] avs_readdata,
   output var logic avs_waitrequest,
   // Pad side of the pin group
   input wire logic [pin_mux_pkg::NPINS-1:0] pin_in,
   output var logic [pin_mux_pkg::NPINS-1:0] pin_out,
   output var logic [pin_mux_pkg::NPINS-1:0] pin_oe_n,
   output var logic [pin_mux_pkg::NPINS-1:0] pin_pull_en,
   // Other reset sources and internal reset
   input wire logic watchdog_reset,
   output wire logic chip_reset,
   // Clock sources for the clock output pin
   input wire logic main_system_clock,
   input wire logic peripheral_bus_clock,
   input wire logic osc_clock,
   // Timer channels
   input wire logic timer0_out,
   input wire logic timer0_oe,
   input wire logic timer1_out,
   input wire logic timer1_oe,
   output var logic timer0_in,
   output var logic timer1_in,
   // PWM fault towards the PWM block
   output var logic pwm_fault_input_three
);
   import pin_mux_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [FUNC_W-1:0] func_r, func_nxt;
   logic [CLKSEL_W-1:0] clksel_r, clksel_nxt;
   logic [NPINS-1:0] dir_r, dir_nxt;
   logic [NPINS-1:0] dout_r, dout_nxt;
   logic sw_r, sw_nxt;
   logic wait_nxt;
   logic [DATA_W-1:0] rdata_nxt;
   logic wr_go, rd_go;
   logic hold;
   logic [1:0] b4_fn, b5_fn;
   logic [NPINS-1:0] gsel, gp_out, gp_oe_n;
   logic [NPINS-1:0] out_nxt, oe_n_nxt, pull_nxt;
   logic t0_nxt, t1_nxt, f3_nxt;
   logic tck_in, tms_in, tdi_in, rise, fall;
   logic tck_q_r;
   tap_st_t st_r, st_nxt;
   logic [IR_W-1:0] ir_r, ir_nxt, ir_sh_r, ir_sh_nxt;
   logic byp_r, byp_nxt;
   logic tdo_r, tdo_nxt, tdo_en_r, tdo_en_nxt;

   reset_ctl_if rc ();
   clock_output_pin_if ck ();

   // ----------------------------------------------------------------
   // Helper blocks
   // ----------------------------------------------------------------
   reset_release u_rel (
      .ref_clk(ref_clk),
      .rst(rst),
      .rc(rc)
   );

   clock_output_pin_select u_clock_output_pin (
      .ref_clk(ref_clk),
      .rst(rst),
      .ck(ck)
   );

   // External reset path is ignored once the pin is a port bit
   assign rc.ext_reset_n = pin_in[PIN_A7];
   assign rc.ext_en = ~func_r[FN_RST_GPIO];
   assign rc.wdog = watchdog_reset;
   assign rc.sw_req = sw_r;
   assign hold = rc.hold;
   assign chip_reset = rc.hold;

   assign ck.sel = clksel_r;
   assign ck.main_lvl = main_system_clock;
   assign ck.bus_lvl = peripheral_bus_clock;
   assign ck.osc_lvl = osc_clock;

   // ----------------------------------------------------------------
   // Register slave
   // ----------------------------------------------------------------
   // One wait cycle per access: answer registered, then
   // waitrequest low for one cycle.
   always_comb begin
      rd_go = avs_read & avs_waitrequest;
      wr_go = avs_write & ~avs_waitrequest;
      wait_nxt = ~((avs_read | avs_write) & avs_waitrequest);
      rdata_nxt = avs_readdata;
      if (rd_go) begin
         rdata_nxt = '0;
         case (avs_address)
            OFS_FUNC: rdata_nxt[FUNC_W-1:0] = func_r;
            OFS_CLKSEL: rdata_nxt[CLKSEL_W-1:0] = clksel_r;
            OFS_DIR: rdata_nxt[NPINS-1:0] = dir_r;
            OFS_DOUT: rdata_nxt[NPINS-1:0] = dout_r;
            OFS_DIN: rdata_nxt[NPINS-1:0] = pin_in;
            OFS_STAT: begin
               rdata_nxt[ST_FAULT] = pwm_fault_input_three;
               rdata_nxt[ST_TAP_SHIFT] = tdo_en_r;
               rdata_nxt[ST_TAP_TLR] = (st_r == TLR);
               rdata_nxt[ST_EXT_RST] = rc.ext_en;
            end
            default: rdata_nxt = '0;
         endcase
      end
   end

   always_comb begin
      func_nxt = func_r;
      clksel_nxt = clksel_r;
      dir_nxt = dir_r;
      dout_nxt = dout_r;
      sw_nxt = 1'b0;
      if (wr_go) begin
         case (avs_address)
            OFS_FUNC: func_nxt = avs_writedata[FUNC_W-1:0];
            OFS_CLKSEL: clksel_nxt = avs_writedata[CLKSEL_W-1:0];
            OFS_DIR: dir_nxt = avs_writedata[NPINS-1:0];
            OFS_DOUT: dout_nxt = avs_writedata[NPINS-1:0];
            OFS_SWRST: sw_nxt = avs_writedata[0];
            default: sw_nxt = 1'b0;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= '0;
      end else begin
         avs_waitrequest <= wait_nxt;
         avs_readdata <= rdata_nxt;
      end
   end

   // Any chip reset restores the defaults, not only power-on
   always_ff @(posedge ref_clk) begin
      if (rst | hold) begin
         func_r <= FUNC_RST;
         clksel_r <= CLKSEL_RST;
         dir_r <= '0;
         dout_r <= '0;
         sw_r <= 1'b0;
      end else begin
         func_r <= func_nxt;
         clksel_r <= clksel_nxt;
         dir_r <= dir_nxt;
         dout_r <= dout_nxt;
         sw_r <= sw_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Function decode
   // ----------------------------------------------------------------
   always_comb begin
      b4_fn = func_r[FN_B4_LSB +: 2];
      b5_fn = func_r[FN_B5_LSB +: 2];
      gsel[PIN_A7] = func_r[FN_RST_GPIO];
      gsel[PIN_B4] = (b4_fn == B4_GPIO);
      gsel[PIN_B5] = (b5_fn == B5_GPIO);
      gsel[PIN_D0] = func_r[FN_D0];
      gsel[PIN_D1] = func_r[FN_D1];
      gsel[PIN_D2] = func_r[FN_D2];
      gsel[PIN_D3] = func_r[FN_D3];
   end

   // ----------------------------------------------------------------
   // Port bits
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi++) begin : g_gpio
         assign gp_out[gi] = gsel[gi] & dout_r[gi];
         assign gp_oe_n[gi] = ~(gsel[gi] & dir_r[gi]);
      end
   endgenerate

   // ----------------------------------------------------------------
   // Pad drive
   // ----------------------------------------------------------------
   // Pull-ups follow the enables so a released pad never floats.
   always_comb begin
      out_nxt = gp_out;
      oe_n_nxt = gp_oe_n;
      // Open drain: only a low is ever driven
      out_nxt[PIN_A7] = 1'b0;
      oe_n_nxt[PIN_A7] = ~(gsel[PIN_A7] & dir_r[PIN_A7]
                          & ~dout_r[PIN_A7]);
      case (b4_fn)
         B4_TIMER: begin
            out_nxt[PIN_B4] = timer0_out;
            oe_n_nxt[PIN_B4] = ~timer0_oe;
         end
         B4_CLOCK_OUTPUT_PIN: begin
            out_nxt[PIN_B4] = ck.out;
            oe_n_nxt[PIN_B4] = 1'b0;
         end
         default: ;
      endcase
      case (b5_fn)
         B5_TIMER: begin
            out_nxt[PIN_B5] = timer1_out;
            oe_n_nxt[PIN_B5] = ~timer1_oe;
         end
         default: ;
      endcase
      if (~gsel[PIN_D1]) begin
         out_nxt[PIN_D1] = tdo_r;
         oe_n_nxt[PIN_D1] = ~tdo_en_r;
      end
      pull_nxt = oe_n_nxt;
      if (hold) begin
         out_nxt = '0;
         oe_n_nxt = '1;
         pull_nxt = '1;
      end
   end

   // ----------------------------------------------------------------
   // Peripheral inputs
   // ----------------------------------------------------------------
   always_comb begin
      t0_nxt = ~hold & (b4_fn == B4_TIMER) & pin_in[PIN_B4];
      t1_nxt = ~hold & (b5_fn == B5_TIMER) & pin_in[PIN_B5];
      f3_nxt = ~hold & (b5_fn == B5_FAULT)
               & (pin_in[PIN_B5] == FAULT_LVL);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_out <= '0;
         pin_oe_n <= '1;
         pin_pull_en <= '1;
         timer0_in <= 1'b0;
         timer1_in <= 1'b0;
         pwm_fault_input_three <= 1'b0;
      end else begin
         pin_out <= out_nxt;
         pin_oe_n <= oe_n_nxt;
         pin_pull_en <= pull_nxt;
         timer0_in <= t0_nxt;
         timer1_in <= t1_nxt;
         pwm_fault_input_three <= f3_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Test access port
   // ----------------------------------------------------------------
   // The test clock is sampled by ref_clk, so it must stay well below
   // half the system rate; port-mode pins park it with mode select high.
   always_comb begin
      tck_in = ~gsel[PIN_D2] & pin_in[PIN_D2];
      tms_in = gsel[PIN_D3] | pin_in[PIN_D3];
      tdi_in = gsel[PIN_D0] | pin_in[PIN_D0];
      rise = tck_in & ~tck_q_r;
      fall = ~tck_in & tck_q_r;
   end

   always_comb begin
      st_nxt = st_r;
      ir_nxt = ir_r;
      ir_sh_nxt = ir_sh_r;
      byp_nxt = byp_r;
      tdo_nxt = tdo_r;
      tdo_en_nxt = tdo_en_r;
      if (rise) begin
         case (st_r)
            TLR: st_nxt = tms_in ? TLR : RTI;
            RTI: st_nxt = tms_in ? SEL_DR : RTI;
            SEL_DR: st_nxt = tms_in ? SEL_IR : CAP_DR;
            CAP_DR: st_nxt = tms_in ? EX1_DR : SH_DR;
            SH_DR: st_nxt = tms_in ? EX1_DR : SH_DR;
            EX1_DR: st_nxt = tms_in ? UPD_DR : PAU_DR;
            PAU_DR: st_nxt = tms_in ? EX2_DR : PAU_DR;
            EX2_DR: st_nxt = tms_in ? UPD_DR : SH_DR;
            UPD_DR: st_nxt = tms_in ? SEL_DR : RTI;
            SEL_IR: st_nxt = tms_in ? TLR : CAP_IR;
            CAP_IR: st_nxt = tms_in ? EX1_IR : SH_IR;
            SH_IR: st_nxt = tms_in ? EX1_IR : SH_IR;
            EX1_IR: st_nxt = tms_in ? UPD_IR : PAU_IR;
            PAU_IR: st_nxt = tms_in ? EX2_IR : PAU_IR;
            EX2_IR: st_nxt = tms_in ? UPD_IR : SH_IR;
            UPD_IR: st_nxt = tms_in ? SEL_DR : RTI;
            default: st_nxt = TLR;
         endcase
         case (st_r)
            TLR: ir_nxt = IR_BYPASS;
            CAP_IR: ir_sh_nxt = IR_CAPTURE;
            SH_IR: ir_sh_nxt = {tdi_in, ir_sh_r[IR_W-1:1]};
            UPD_IR: ir_nxt = ir_sh_r;
            CAP_DR: byp_nxt = 1'b0;
            SH_DR: byp_nxt = tdi_in;
            default: ;
         endcase
      end
      if (fall) begin
         tdo_en_nxt = (st_r == SH_IR) | (st_r == SH_DR);
         tdo_nxt = (st_r == SH_IR) ? ir_sh_r[0] : byp_r;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tck_q_r <= 1'b0;
         st_r <= TLR;
         ir_r <= IR_BYPASS;
         ir_sh_r <= '0;
         byp_r <= 1'b0;
         tdo_r <= 1'b0;
         tdo_en_r <= 1'b0;
      end else begin
         tck_q_r <= tck_in;
         st_r <= st_nxt;
         ir_r <= ir_nxt;
         ir_sh_r <= ir_sh_nxt;
         byp_r <= byp_nxt;
         tdo_r <= tdo_nxt;
         tdo_en_r <= tdo_en_nxt;
      end
   end

endmodule : reset_test_timer_pin_mux

`default_nettype wire

/* logic/pin_mux_pkg.sv */
// Constants and types of the reset, timer and test pin multiplexer
// Contract
// - Low reset pin holds chip in reset
// - Internal reset releases after fixed clock count
// - Reset pin as port disables external reset
// - Reset pin port: input or open drain only
// - Reset pin defaults to reset function
// - During reset all pins input with pull-up
// - Clock output: off, main, bus or oscillator
// - Timer zero pin defaults to port B bit4
// - Timer one pin defaults to port B bit5
// - Selected fault input disables chosen PWM outputs
// - Test pins default to boundary-scan functions
// - Mode select sampled on rising test clock
// - Test data in sampled, shifted on rising edge
// - Each port pin direction set independently
// - Test data out only in shift states, falling
`default_nettype none

package pin_mux_pkg;

   // ----------------------------------------------------------------
   // Register map, byte addresses on the Avalon-MM slave
   // ----------------------------------------------------------------
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFS_FUNC = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_CLKSEL = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_DIR = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_DOUT = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_DIN = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_STAT = 5'h14;
   localparam logic [ADDR_W-1:0] OFS_SWRST = 5'h18;

   // ----------------------------------------------------------------
   // Pin indices of the group
   // ----------------------------------------------------------------
   localparam int NPINS = 7;
   localparam int PIN_A7 = 0;
   localparam int PIN_B4 = 1;
   localparam int PIN_B5 = 2;
   localparam int PIN_D0 = 3;
   localparam int PIN_D1 = 4;
   localparam int PIN_D2 = 5;
   localparam int PIN_D3 = 6;

   // ----------------------------------------------------------------
   // Function select fields
   // ----------------------------------------------------------------
   localparam int FUNC_W = 9;
   localparam int FN_RST_GPIO = 0;
   localparam int FN_B4_LSB = 1;
   localparam int FN_B5_LSB = 3;
   localparam int FN_D0 = 5;
   localparam int FN_D1 = 6;
   localparam int FN_D2 = 7;
   localparam int FN_D3 = 8;
   localparam logic [FUNC_W-1:0] FUNC_RST = 9'h000;
   localparam logic [1:0] B4_GPIO = 2'h0;
   localparam logic [1:0] B4_TIMER = 2'h1;
   localparam logic [1:0] B4_CLOCK_OUTPUT_PIN = 2'h2;
   localparam logic [1:0] B5_GPIO = 2'h0;
   localparam logic [1:0] B5_TIMER = 2'h1;
   localparam logic [1:0] B5_FAULT = 2'h2;

   // ----------------------------------------------------------------
   // Clock output select
   // ----------------------------------------------------------------
   localparam int CLKSEL_W = 2;
   localparam logic [CLKSEL_W-1:0] CLOCK_OUTPUT_PIN_OFF = 2'h0;
   localparam logic [CLKSEL_W-1:0] CLOCK_OUTPUT_PIN_MAIN = 2'h1;
   localparam logic [CLKSEL_W-1:0] CLOCK_OUTPUT_PIN_BUS = 2'h2;
   localparam logic [CLKSEL_W-1:0] CLOCK_OUTPUT_PIN_OSC = 2'h3;
   localparam logic [CLKSEL_W-1:0] CLKSEL_RST = 2'h0;

   // ----------------------------------------------------------------
   // Status bits, reset release, test port
   // ----------------------------------------------------------------
   localparam int ST_FAULT = 0;
   localparam int ST_TAP_SHIFT = 1;
   localparam int ST_TAP_TLR = 2;
   localparam int ST_EXT_RST = 3;
   localparam int RST_CNT_W = 6;
   localparam logic [RST_CNT_W-1:0] RST_HOLD_CYCLES = 6'h20;
   localparam logic FAULT_LVL = 1'b1;
   localparam int IR_W = 4;
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
   localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;

   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR,
      UPD_DR, SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } tap_st_t;

endpackage : pin_mux_pkg

`default_nettype wire

/* logic/mux_links_if.sv */
// Interfaces between the pin multiplexer and its helper blocks
`timescale 1ns/1ps
`default_nettype none

interface reset_ctl_if;
   logic ext_reset_n;
   logic ext_en;
   logic wdog;
   logic sw_req;
   logic hold;
   modport mux (output ext_reset_n, ext_en, wdog, sw_req, input hold);
   modport rel (input ext_reset_n, ext_en, wdog, sw_req, output hold);
endinterface : reset_ctl_if

interface clock_output_pin_if;
   logic [pin_mux_pkg::CLKSEL_W-1:0] sel;
   logic main_lvl;
   logic bus_lvl;
   logic osc_lvl;
   logic out;
   modport mux (output sel, main_lvl, bus_lvl, osc_lvl, input out);
   modport src (input sel, main_lvl, bus_lvl, osc_lvl, output out);
endinterface : clock_output_pin_if

`default_nettype wire

/* logic/reset_release.sv */
// Internal reset generator with counted synchronous release
`timescale 1ns/1ps
`default_nettype none

module reset_release (
   // Clock and power-on reset
   input wire logic ref_clk,
   input wire logic rst,
   // Reset sources and internal reset
   reset_ctl_if.rel rc
);
   import pin_mux_pkg::*;

   logic [RST_CNT_W-1:0] cnt_r, cnt_nxt;
   logic hold_r, hold_nxt;
   logic src;

   always_comb begin
      src = (rc.ext_en & ~rc.ext_reset_n) | rc.wdog | rc.sw_req;
      cnt_nxt = cnt_r;
      if (src)
         cnt_nxt = '0;
      else if (cnt_r != RST_HOLD_CYCLES)
         cnt_nxt = cnt_r + 1'b1;
      hold_nxt = src | (cnt_r != RST_HOLD_CYCLES);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_r <= '0;
         hold_r <= 1'b1;
      end else begin
         cnt_r <= cnt_nxt;
         hold_r <= hold_nxt;
      end
   end

   assign rc.hold = hold_r;

endmodule : reset_release

`default_nettype wire

/* logic/clock_output_pin_select.sv */
// Registered source selector for the clock output pin
`timescale 1ns/1ps
`default_nettype none

module clock_output_pin_select (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Selection and sources
   clock_output_pin_if.src ck
);
   import pin_mux_pkg::*;

   logic out_r, out_nxt;

   always_comb begin
      case (ck.sel)
         CLOCK_OUTPUT_PIN_MAIN: out_nxt = ck.main_lvl;
         CLOCK_OUTPUT_PIN_BUS: out_nxt = ck.bus_lvl;
         CLOCK_OUTPUT_PIN_OSC: out_nxt = ck.osc_lvl;
         default: out_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst)
         out_r <= 1'b0;
      else
         out_r <= out_nxt;
   end

   assign ck.out = out_r;

endmodule : clock_output_pin_select

`default_nettype wire

/* tb/pin_mux_props.sv */
// Concurrent checks on the ports of the pin multiplexer
`timescale 1ns/1ps
`default_nettype none

module pin_mux_props (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register bus
   input wire logic [pin_mux_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [pin_mux_pkg::DATA_W-1:0] avs_writedata,
   input wire logic avs_waitrequest,
   // Pads and side signals
   input wire logic [pin_mux_pkg::NPINS-1:0] pin_in,
   input wire logic [pin_mux_pkg::NPINS-1:0] pin_out,
   input wire logic [pin_mux_pkg::NPINS-1:0] pin_oe_n,
   input wire logic [pin_mux_pkg::NPINS-1:0] pin_pull_en,
   input wire logic watchdog_reset,
   input wire logic chip_reset,
   input wire logic timer0_out,
   input wire logic timer0_oe,
   input wire logic pwm_fault_input_three
);
   import pin_mux_pkg::*;
   logic [FUNC_W-1:0] func_r, func_nxt;
   logic [CLKSEL_W-1:0] sel_r, sel_nxt;
   logic wr_ok;
   // Shadow of config writes; lost during chip reset
   always_comb begin
      wr_ok = avs_write && !avs_waitrequest && !chip_reset;
      func_nxt = chip_reset ? FUNC_RST : func_r;
      sel_nxt = chip_reset ? CLKSEL_RST : sel_r;
      if (wr_ok && avs_address == OFS_FUNC)
         func_nxt = avs_writedata[FUNC_W-1:0];
      if (wr_ok && avs_address == OFS_CLKSEL)
         sel_nxt = avs_writedata[CLKSEL_W-1:0];
   end
   always_ff @(posedge ref_clk) begin
      func_r <= rst ? FUNC_RST : func_nxt;
      sel_r <= rst ? CLKSEL_RST : sel_nxt;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_req_wait;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_pin_low;
      (!func_r[FN_RST_GPIO] && !pin_in[PIN_A7])[*2];
   endsequence
   property p_bus_answer;
      s_req_wait |=> !avs_waitrequest;
   endproperty
   property p_ext_reset;
      s_pin_low |-> ##[0:2] chip_reset;
   endproperty
   property p_release;
      $fell(chip_reset) |-> $past(chip_reset, 32);
   endproperty
   property p_wdog;
      watchdog_reset |-> ##[1:3] chip_reset;
   endproperty
   property p_hold_pins;
      chip_reset[*3] |-> pin_oe_n == '1 && pin_pull_en == '1;
   endproperty
   property p_open_drain;
      !pin_oe_n[PIN_A7] |-> !pin_out[PIN_A7];
   endproperty
   property p_clock_output_pin_off;
      (func_r[FN_B4_LSB+:2] == B4_CLOCK_OUTPUT_PIN && sel_r == CLOCK_OUTPUT_PIN_OFF
         && !chip_reset)[*4] |-> !pin_out[PIN_B4] && !pin_oe_n[PIN_B4];
   endproperty
   property p_timer0;
      (func_r[FN_B4_LSB+:2] == B4_TIMER && timer0_oe && timer0_out
         && !chip_reset)[*3] |-> pin_out[PIN_B4] && !pin_oe_n[PIN_B4];
   endproperty
   property p_fault;
      (func_r[FN_B5_LSB+:2] == B5_FAULT && !chip_reset)[*2]
         |-> pwm_fault_input_three == $past(pin_in[PIN_B5]);
   endproperty
   property p_tdo_fall;
      !chip_reset && !func_r[FN_D1] && !func_r[FN_D2]
         && $changed(pin_oe_n[PIN_D1]) |-> !pin_in[PIN_D2];
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("no bus answer");
   a_ext_reset: assert property (p_ext_reset) else $error("pin ignored");
   a_release: assert property (p_release) else $error("early release");
   a_wdog: assert property (p_wdog) else $error("watchdog reset missed");
   a_hold_pins: assert property (p_hold_pins) else $error("pins active");
   a_open_drain: assert property (p_open_drain) else $error("pin high");
   a_clock_output_pin_off: assert property (p_clock_output_pin_off) else $error("clock not low");
   a_timer0: assert property (p_timer0) else $error("timer zero absent");
   a_fault: assert property (p_fault) else $error("fault mismatch");
   a_tdo_fall: assert property (p_tdo_fall) else $error("not on fall");
endmodule : pin_mux_props

`default_nettype wire

/* tb/board_model.sv */
// Board side of the pin group: pads, pull-ups and test equipment
`timescale 1ns/1ps
`default_nettype none

module board_model (
   // Clock
   input wire logic ref_clk,
   // Device pads
   input wire logic [pin_mux_pkg::NPINS-1:0] pin_out,
   input wire logic [pin_mux_pkg::NPINS-1:0] pin_oe_n,
   input wire logic [pin_mux_pkg::NPINS-1:0] pin_pull_en,
   // Board drive per pin
   input wire logic [pin_mux_pkg::NPINS-1:0] drv,
   input wire logic [pin_mux_pkg::NPINS-1:0] drv_en,
   // Resolved pad levels
   output logic [pin_mux_pkg::NPINS-1:0] pin_in
);
   import pin_mux_pkg::*;
   logic [NPINS-1:0] last_r = 7'h00;
   // A floating pad with no pull-up shows the inverse of its last level
   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
         else if (drv_en[i]) pin_in[i] = drv[i];
         else if (pin_pull_en[i]) pin_in[i] = 1'h1;
         else pin_in[i] = !last_r[i];
      end
   end
   always @(posedge ref_clk) last_r <= pin_in;
endmodule : board_model

`default_nettype wire

/* tb/reset_test_timer_pin_mux_bench.sv */
// Self-checking bench for the reset, timer and test pin multiplexer
`timescale 1ns/1ps
`default_nettype none

module reset_test_timer_pin_mux_bench;
   import pin_mux_pkg::*;
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic [ADDR_W-1:0] avs_address = 5'h00;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [DATA_W-1:0] avs_writedata = 32'h0;
   wire logic [DATA_W-1:0] avs_readdata;
   wire logic avs_waitrequest, chip_reset, t0_in, t1_in, fault;
   wire logic [NPINS-1:0] pin_in, pin_out, pin_oe_n, pin_pull_en;
   // Board idle: reset pin high, test clock low, mode and data high
   logic [NPINS-1:0] drv = 7'h49;
   logic [NPINS-1:0] drv_en = 7'h6F;
   logic wdog = 1'h0;
   logic [2:0] src = 3'h0;
   logic [3:0] tmr = 4'h0;
   logic [DATA_W-1:0] rd;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   int n;

   initial forever #12.5 ref_clk = ~ref_clk;

   reset_test_timer_pin_mux dut_u (.ref_clk, .rst, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .pin_in, .pin_out, .pin_oe_n, .pin_pull_en,
      .watchdog_reset(wdog), .chip_reset, .main_system_clock(src[2]),
      .peripheral_bus_clock(src[1]), .osc_clock(src[0]),
      .timer0_out(tmr[0]), .timer0_oe(tmr[1]), .timer1_out(tmr[2]),
      .timer1_oe(tmr[3]), .timer0_in(t0_in), .timer1_in(t1_in),
      .pwm_fault_input_three(fault));

   board_model u_board (.ref_clk, .pin_out, .pin_oe_n, .pin_pull_en,
      .drv, .drv_en, .pin_in);

   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [DATA_W-1:0] got, exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic ticks(input int k);
      repeat (k) @(posedge ref_clk);
   endtask : ticks

   // One Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'h0);
      rd = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask : bus

   task automatic rdchk(input logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
      bus(1'h0, a, 32'h0);
      chk(rd, e);
   endtask : rdchk

   task automatic wait_rel;
      n = 0;
      while (chip_reset !== 1'h0) begin
         ticks(1);
         n++;
      end
   endtask : wait_rel

   // One test clock period, settled on return
   task automatic tck(input logic tms, input logic tdi);
      drv[PIN_D3] <= tms;
      drv[PIN_D0] <= tdi;
      ticks(3);
      drv[PIN_D2] <= 1'h1;
      ticks(3);
      drv[PIN_D2] <= 1'h0;
      ticks(4);
   endtask : tck

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_sim();
      end
   end

   initial begin
      ticks(5);
      rst <= 1'h0;
      ticks(2);
      chk(pin_oe_n, 7'h7F);
      chk(pin_pull_en, 7'h7F);
      wait_rel();
      chk(n >= 32, 1'h1);
      rdchk(OFS_FUNC, 32'h0);
      rdchk(OFS_STAT, 32'hC);
      rdchk(OFS_DIN, 32'h59);
      rdchk(5'h1C, 32'h0);
      bus(1'h1, OFS_DIR, 32'h2);
      bus(1'h1, OFS_DOUT, 32'h2);
      ticks(3);
      chk(pin_oe_n[2:1], 2'h2);
      chk(pin_out[PIN_B4], 1'h1);
      bus(1'h1, OFS_DIR, 32'h4);
      ticks(3);
      chk(pin_oe_n[2:1], 2'h1);
      bus(1'h1, OFS_DIR, 32'h1);
      bus(1'h1, OFS_DOUT, 32'h1);
      bus(1'h1, OFS_FUNC, 32'h1);
      drv_en[PIN_A7] <= 1'h0;
      ticks(3);
      chk(pin_oe_n[PIN_A7], 1'h1);
      bus(1'h1, OFS_DOUT, 32'h0);
      ticks(3);
      chk({pin_oe_n[PIN_A7], pin_in[PIN_A7]}, 2'h0);
      ticks(40);
      chk(chip_reset, 1'h0);
      rdchk(OFS_STAT, 32'h4);
      bus(1'h1, OFS_DIR, 32'h0);
      drv_en[PIN_A7] <= 1'h1;
      bus(1'h1, OFS_CLKSEL, 32'h3);
      bus(1'h1, OFS_FUNC, 32'h0);
      ticks(5);
      chk(chip_reset, 1'h0);
      drv[PIN_A7] <= 1'h0;
      ticks(50);
      chk(chip_reset, 1'h1);
      chk(pin_oe_n, 7'h7F);
      drv[PIN_A7] <= 1'h1;
      wait_rel();
      chk(n >= 32, 1'h1);
      rdchk(OFS_CLKSEL, 32'h0);
      bus(1'h1, OFS_FUNC, 32'h10);
      drv[PIN_B5] <= 1'h1;
      ticks(3);
      chk(fault, 1'h1);
      rdchk(OFS_STAT, 32'hD);
      drv[PIN_B5] <= 1'h0;
      ticks(3);
      chk(fault, 1'h0);
      wdog <= 1'h1;
      ticks(2);
      wdog <= 1'h0;
      ticks(2);
      chk(chip_reset, 1'h1);
      wait_rel();
      rdchk(OFS_FUNC, 32'h0);
      bus(1'h1, OFS_FUNC, 32'hA);
      tmr <= 4'h7;
      drv[PIN_B5] <= 1'h1;
      ticks(3);
      chk({pin_out[PIN_B4], pin_oe_n[PIN_B4], t0_in}, 3'h5);
      chk({t1_in, pin_oe_n[PIN_B5]}, 2'h3);
      bus(1'h1, OFS_SWRST, 32'h1);
      ticks(2);
      chk(chip_reset, 1'h1);
      wait_rel();
      rdchk(OFS_FUNC, 32'h0);
      bus(1'h1, OFS_FUNC, 32'h4);
      for (int s = 0; s < 4; s++) begin
         bus(1'h1, OFS_CLKSEL, DATA_W'(s));
         for (int p = 0; p < 2; p++) begin
            src <= p ? 3'h2 : 3'h5;
            ticks(4);
            chk(pin_out[PIN_B4], s == 0 ? 1'h0 : src[3-s]);
         end
      end
      tck(1'h0, 1'h1);
      tck(1'h1, 1'h1);
      tck(1'h1, 1'h1);
      tck(1'h0, 1'h1);
      tck(1'h0, 1'h0);
      chk({pin_oe_n[PIN_D1], pin_out[PIN_D1]}, 2'h1);
      rdchk(OFS_STAT, 32'hA);
      for (int i = 0; i < 4; i++) begin
         tck(1'h0, i == 0);
         chk(pin_out[PIN_D1], i == 3);
      end
      tck(1'h1, 1'h0);
      chk({pin_oe_n[PIN_D1], pin_in[PIN_D1]}, 2'h3);
      repeat (4) tck(1'h1, 1'h0);
      rdchk(OFS_STAT, 32'hC);
      end_sim();
   end
endmodule : reset_test_timer_pin_mux_bench

bind reset_test_timer_pin_mux pin_mux_props u_props (.ref_clk, .rst,
   .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_waitrequest, .pin_in, .pin_out, .pin_oe_n, .pin_pull_en,
   .watchdog_reset, .chip_reset, .timer0_out, .timer0_oe,
   .pwm_fault_input_three);

`default_nettype wire
